// File: apdu_decoder.v
// card command header decoder with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "apdu_decoder_map.vh"

module apdu_decoder (
  input  wire        core_clk_in,
  input  wire        resetn_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [4:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  input  wire        rx_valid_in,
  input  wire [7:0]  rx_byte_in,
  output reg         tx_valid_out,
  output reg  [7:0]  tx_byte_out
);

  localparam [3:0] ST_HDR  = 4'b0001;
  localparam [3:0] ST_DIN  = 4'b0010;
  localparam [3:0] ST_EXEC = 4'b0100;
  localparam [3:0] ST_SW   = 4'b1000;

  // data direction of each instruction
  function [1:0] dir_of;
    input [7:0] ins;
    begin
      case (ins)
        `INS_SELECT, `INS_SEEK, `INS_INCREASE,
        `INS_AUTH, `INS_ENVELOPE: dir_of = `DIR_BOTH;
        `INS_STATUS, `INS_RD_BIN, `INS_RD_REC,
        `INS_GET_RSP, `INS_FETCH: dir_of = `DIR_OUT;
        `INS_UPD_BIN, `INS_UPD_REC, `INS_VERIFY,
        `INS_CHANGE, `INS_DISABLE, `INS_ENABLE,
        `INS_UNLOCK, `INS_PROFILE,
        `INS_TERM_RSP: dir_of = `DIR_IN;
        default: dir_of = `DIR_NONE;
      endcase
    end
  endfunction

  function known;
    input [7:0] ins;
    begin
      case (ins)
        `INS_SELECT, `INS_STATUS, `INS_RD_BIN,
        `INS_UPD_BIN, `INS_RD_REC, `INS_UPD_REC,
        `INS_SEEK, `INS_INCREASE, `INS_VERIFY,
        `INS_CHANGE, `INS_DISABLE, `INS_ENABLE,
        `INS_UNLOCK, `INS_INVAL, `INS_REHAB,
        `INS_AUTH, `INS_SLEEP, `INS_GET_RSP,
        `INS_PROFILE, `INS_ENVELOPE, `INS_FETCH,
        `INS_TERM_RSP: known = 1'b1;
        default: known = 1'b0;
      endcase
    end
  endfunction

  function reserved;
    input [7:0] ins;
    begin
      case (ins)
        8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e: reserved = 1'b1;
        8'h2a, 8'hd0, 8'hd2, 8'hde, 8'hc4, 8'hc6, 8'hc8,
        8'hca, 8'hcc, 8'hb4, 8'hb6, 8'hb8, 8'hba,
        8'hbb, 8'hbc: reserved = 1'b1;
        default: reserved = 1'b0;
      endcase
    end
  endfunction

  // required P3 for fixed-length commands, zero when free
  function [7:0] fixed_len;
    input [7:0] ins;
    begin
      case (ins)
        `INS_SELECT: fixed_len = 8'h02;
        `INS_INCREASE: fixed_len = 8'h03;
        `INS_VERIFY, `INS_DISABLE,
        `INS_ENABLE: fixed_len = 8'h08;
        `INS_CHANGE, `INS_UNLOCK,
        `INS_AUTH: fixed_len = 8'h10;
        default: fixed_len = 8'h00;
      endcase
    end
  endfunction

  // P2 check for codes that pin it; other P1/P2 values, FF included, pass
  function p2_bad;
    input [7:0] ins;
    input [7:0] p2;
    begin
      case (ins)
        `INS_DISABLE, `INS_ENABLE: p2_bad = (p2 != 8'h01);
        `INS_UNLOCK: p2_bad = (p2 != 8'h00) && (p2 != 8'h02);
        default: p2_bad = 1'b0;
      endcase
    end
  endfunction

  reg [3:0]  state_reg;
  reg [2:0]  hdr_cnt_reg;
  reg [7:0]  cla_t_reg;
  reg [7:0]  ins_t_reg;
  reg [7:0]  p1_t_reg;
  reg [7:0]  p2_t_reg;
  reg [7:0]  ins_reg;
  reg [7:0]  p1_reg;
  reg [7:0]  p2_reg;
  reg [7:0]  p3_reg;
  reg [1:0]  dir_reg;
  reg        cmd_flag_reg;
  reg        rx_flag_reg;
  reg [7:0]  rx_data_reg;
  reg [7:0]  rx_left_reg;
  reg [8:0]  tx_left_reg;
  reg [15:0] sw_reg;
  reg        snd_cnt_reg;
  reg [7:0]  pend_len_reg;
  reg        pend_kind_reg;
  reg        pend_valid_reg;

  wire acc = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wr  = acc & wb_we_in & wb_sel_in[0];
  wire rd  = acc & ~wb_we_in;

  wire wr_stat = wr && (wb_adr_in == `OFS_STAT);
  wire wr_txd  = wr && (wb_adr_in == `OFS_TXD);
  wire wr_sw   = wr && (wb_adr_in == `OFS_SW);
  wire wr_pend = wr && (wb_adr_in == `OFS_PEND);
  wire rd_rxd  = rd && (wb_adr_in == `OFS_RXD);

  // header decode on the fifth byte, P3 taken straight from the link
  wire       hdr_last = (state_reg == ST_HDR) && rx_valid_in &&
                        (hdr_cnt_reg == 3'd4);
  wire [1:0] dec_dir  = dir_of(ins_t_reg);
  wire [7:0] need_len = fixed_len(ins_t_reg);
  reg [15:0] err_w;

  always @* begin
    err_w = 16'h0000;
    if (cla_t_reg != `CLA_APP)
      err_w = `ERR_CLA;
    else if (reserved(ins_t_reg) || !known(ins_t_reg))
      err_w = `ERR_INS;
    else if ((need_len != 8'h00) && (rx_byte_in != need_len))
      err_w = `ERR_LEN;
    else if (p2_bad(ins_t_reg, p2_t_reg))
      err_w = `ERR_P12;
  end

  wire dec_in  = dec_dir[0];
  wire dec_out = (dec_dir == `DIR_OUT);

  // flags: a hardware set in the same cycle as a clear wins
  wire cmd_set = hdr_last && (err_w == 16'h0000);
  wire cmd_clr = wr_stat && wb_dat_in[`STAT_CMD_BIT];
  wire rx_set  = (state_reg == ST_DIN) && rx_valid_in;

  reg [31:0] rd_w;
  always @* begin
    case (wb_adr_in)
      `OFS_HDR:  rd_w = {`CLA_APP, ins_reg, p1_reg, p2_reg};
      `OFS_STAT: rd_w = {7'h00, tx_left_reg, state_reg, rx_flag_reg,
                         cmd_flag_reg, dir_reg, p3_reg};
      `OFS_RXD:  rd_w = {24'h000000, rx_data_reg};
      `OFS_SW:   rd_w = {16'h0000, sw_reg};
      `OFS_PEND: rd_w = {22'h0, pend_valid_reg, pend_kind_reg,
                         pend_len_reg};
      `OFS_OFFS: rd_w = {16'h0000, p1_reg, p2_reg};
      default:   rd_w = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_ack_out     <= 1'b0;
      wb_dat_out     <= 32'h00000000;
      tx_valid_out   <= 1'b0;
      tx_byte_out    <= 8'h00;
      state_reg      <= ST_HDR;
      hdr_cnt_reg    <= 3'd0;
      cla_t_reg      <= 8'h00;
      ins_t_reg      <= 8'h00;
      p1_t_reg       <= 8'h00;
      p2_t_reg       <= 8'h00;
      ins_reg        <= 8'h00;
      p1_reg         <= 8'h00;
      p2_reg         <= 8'h00;
      p3_reg         <= 8'h00;
      dir_reg        <= `DIR_NONE;
      cmd_flag_reg   <= 1'b0;
      rx_flag_reg    <= 1'b0;
      rx_data_reg    <= 8'h00;
      rx_left_reg    <= 8'h00;
      tx_left_reg    <= 9'h000;
      sw_reg         <= 16'h0000;
      snd_cnt_reg    <= 1'b0;
      pend_len_reg   <= 8'h00;
      pend_kind_reg  <= 1'b0;
      pend_valid_reg <= 1'b0;
    end else begin
      wb_ack_out   <= acc;
      wb_dat_out   <= rd ? rd_w : 32'h00000000;
      tx_valid_out <= 1'b0;

      if (cmd_set)
        cmd_flag_reg <= 1'b1;
      else if (cmd_clr)
        cmd_flag_reg <= 1'b0;
      if (rx_set)
        rx_flag_reg <= 1'b1;
      else if (rd_rxd)
        rx_flag_reg <= 1'b0;

      case (state_reg)
        ST_HDR: begin
          if (rx_valid_in) begin
            // bytes held in shadow until the command is accepted
            case (hdr_cnt_reg)
              3'd0: cla_t_reg <= rx_byte_in;
              3'd1: ins_t_reg <= rx_byte_in;
              3'd2: p1_t_reg  <= rx_byte_in;
              3'd3: p2_t_reg  <= rx_byte_in;
              default: ;
            endcase
            hdr_cnt_reg <= hdr_last ? 3'd0 : hdr_cnt_reg + 3'd1;
          end
          if (hdr_last) begin
            if (err_w != 16'h0000) begin
              // rejected: accepted header, lengths and flags stay; only sw_reg, snd_cnt_reg, hdr_cnt_reg and the state field move
              sw_reg      <= err_w;
              snd_cnt_reg <= 1'b0;
              state_reg   <= ST_SW;
            end else begin
              ins_reg <= ins_t_reg;
              p1_reg  <= p1_t_reg;
              p2_reg  <= p2_t_reg;
              p3_reg  <= rx_byte_in;
              dir_reg <= dec_dir;
              if (ins_t_reg == `INS_GET_RSP)
                pend_valid_reg <= 1'b0;
              if (dec_out)
                tx_left_reg <= (rx_byte_in == 8'h00) ? 9'h100 :
                               {1'b0, rx_byte_in};
              else
                tx_left_reg <= 9'h000;
              rx_left_reg <= dec_in ? rx_byte_in : 8'h00;
              if (dec_in && (rx_byte_in != 8'h00))
                state_reg <= ST_DIN;
              else
                state_reg <= ST_EXEC;
            end
          end
        end
        ST_DIN: begin
          if (rx_valid_in) begin
            rx_data_reg <= rx_byte_in;
            rx_left_reg <= rx_left_reg - 8'd1;
            if (rx_left_reg == 8'd1)
              state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // no buffer: software paces outgoing bytes one write at a time
          if (wr_txd && (tx_left_reg != 9'h000)) begin
            tx_valid_out <= 1'b1;
            tx_byte_out  <= wb_dat_in[7:0];
            tx_left_reg  <= tx_left_reg - 9'd1;
          end else if (wr_pend) begin
            pend_len_reg   <= wb_dat_in[7:0];
            pend_kind_reg  <= wb_dat_in[`PEND_KIND_BIT];
            pend_valid_reg <= 1'b1;
            sw_reg <= {wb_dat_in[`PEND_KIND_BIT] ? `SW1_PEND_DL : `SW1_PEND,
                       wb_dat_in[7:0]};
            snd_cnt_reg <= 1'b0;
            state_reg   <= ST_SW;
          end else if (wr_sw) begin
            sw_reg      <= wb_dat_in[15:0];
            snd_cnt_reg <= 1'b0;
            state_reg   <= ST_SW;
          end
        end
        ST_SW: begin
          tx_valid_out <= 1'b1;
          tx_byte_out  <= snd_cnt_reg ? sw_reg[7:0] : sw_reg[15:8];
          snd_cnt_reg  <= ~snd_cnt_reg;
          if (snd_cnt_reg) begin
            state_reg   <= ST_HDR;
            hdr_cnt_reg <= 3'd0;
          end
        end
        default: state_reg <= ST_HDR;
      endcase
    end
  end

endmodule // apdu_decoder

`default_nettype wire

// File: apdu_decoder_map.vh
// constants for the card command decoder
`ifndef APDU_DECODER_MAP_VH
`define APDU_DECODER_MAP_VH
// register byte offsets
`define OFS_HDR  5'h00
`define OFS_STAT 5'h04
`define OFS_RXD  5'h08
`define OFS_TXD  5'h0c
`define OFS_SW   5'h10
`define OFS_PEND 5'h14
`define OFS_OFFS 5'h18
// status register fields
`define STAT_CMD_BIT 10
`define STAT_RX_BIT  11
// pending register fields
`define PEND_KIND_BIT  8
`define PEND_VALID_BIT 9
// class and status bytes
`define CLA_APP      8'ha0
`define SW1_PEND     8'h9f
`define SW1_PEND_DL  8'h9e
`define ERR_CLA      16'h6e00
`define ERR_INS      16'h6d00
`define ERR_LEN      16'h6700
`define ERR_P12      16'h6b00
// instruction codes
`define INS_SELECT   8'ha4
`define INS_STATUS   8'hf2
`define INS_RD_BIN   8'hb0
`define INS_UPD_BIN  8'hd6
`define INS_RD_REC   8'hb2
`define INS_UPD_REC  8'hdc
`define INS_SEEK     8'ha2
`define INS_INCREASE 8'h32
`define INS_VERIFY   8'h20
`define INS_CHANGE   8'h24
`define INS_DISABLE  8'h26
`define INS_ENABLE   8'h28
`define INS_UNLOCK   8'h2c
`define INS_INVAL    8'h04
`define INS_REHAB    8'h44
`define INS_AUTH     8'h88
`define INS_SLEEP    8'hfa
`define INS_GET_RSP  8'hc0
`define INS_PROFILE  8'h10
`define INS_ENVELOPE 8'hc2
`define INS_FETCH    8'h12
`define INS_TERM_RSP 8'h14
// data directions
`define DIR_NONE 2'h0
`define DIR_IN   2'h1
`define DIR_OUT  2'h2
`define DIR_BOTH 2'h3
`endif

// File: apdu_decoder_properties.sv
// port checker for the card command decoder
`timescale 1ns/1ps
`default_nettype none
module apdu_decoder_properties (
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [4:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        rx_valid_in,
  input wire logic [7:0]  rx_byte_in,
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_byte_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [2:0] cnt_reg;
  logic       cla_bad_reg;
  logic       ins_bad_reg;
  function automatic logic resv(input logic [7:0] b);
    return (b[7:4] == 4'h1 && !b[0] && b[3:1] > 3'h2) || b inside {8'h2a, 8'hd0, 8'hd2,
      8'hde, 8'hc4, 8'hc6, 8'hc8, 8'hca, 8'hcc, 8'hb4, 8'hb6, 8'hb8, 8'hba, 8'hbb, 8'hbc};
  endfunction
  // header position; any byte sent means a new header comes next
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg <= 3'h0;
      cla_bad_reg <= 1'b0;
      ins_bad_reg <= 1'b0;
    end else if (tx_valid_out) begin
      cnt_reg <= 3'h0;
    end else if (rx_valid_in && cnt_reg < 3'h5) begin
      cnt_reg <= cnt_reg + 3'h1;
      if (cnt_reg == 3'h0) cla_bad_reg <= rx_byte_in != 8'ha0;
      if (cnt_reg == 3'h1) ins_bad_reg <= resv(rx_byte_in);
    end
  end
  chk_ack_timing: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  chk_tx_hold: assert property (!tx_valid_out |-> $stable(tx_byte_out))
    else $error("tx byte moved while idle");
  chk_hdr_class: assert property (wb_ack_out && $past(!wb_we_in && wb_adr_in == 5'h00)
    && wb_dat_out != 32'h0 |-> wb_dat_out[31:24] == 8'ha0) else $error("header class");
  chk_cla_reject: assert property (rx_valid_in && cnt_reg == 3'h4 && cla_bad_reg
    |=> ##[0:2] (tx_valid_out && tx_byte_out == 8'h6e) ##1 (tx_valid_out && tx_byte_out
    == 8'h00)) else $error("foreign class not refused");
  chk_ins_reject: assert property (rx_valid_in && cnt_reg == 3'h4 && !cla_bad_reg
    && ins_bad_reg |=> ##[0:2] (tx_valid_out && tx_byte_out == 8'h6d) ##1 (tx_valid_out
    && tx_byte_out == 8'h00)) else $error("reserved code not refused");
  cover property (rx_valid_in && cnt_reg == 3'h4 && ins_bad_reg);
  cover property (tx_valid_out && tx_byte_out == 8'h9e);
  cover property (wb_ack_out && wb_we_in);
endmodule // apdu_decoder_properties
bind apdu_decoder apdu_decoder_properties u_props (.core_clk_in(core_clk_in),
  .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .rx_valid_in(rx_valid_in),
  .rx_byte_in(rx_byte_in), .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out));
`default_nettype wire

// File: term_model.sv
// handset terminal model: sends header and data bytes, logs card bytes
`timescale 1ns/1ps
`default_nettype none
module term_model (
  input  wire logic       clk_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_byte_in,
  output var  logic       rx_valid_out,
  output var  logic [7:0] rx_byte_out
);
  logic [7:0] got_q [$];
  initial begin
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h00;
  end
  // released line shows the inverse, so a stale byte cannot pass
  task automatic send(input logic [7:0] b);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_byte_out <= b;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~b;
  endtask
  always @(posedge clk_in) begin
    if (tx_valid_in) got_q.push_back(tx_byte_in);
  end
endmodule // term_model
`default_nettype wire

// File: subscriber_card_apdu_decoder_tb.sv
// self-checking bench for the card command decoder
`timescale 1ns/1ps
`default_nettype none
`include "apdu_decoder_map.vh"
module subscriber_card_apdu_decoder_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'hf;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic        ack;
  logic        rxv;
  logic [7:0]  rxb;
  logic        txv;
  logic [7:0]  txb;
  logic [31:0] seed = 32'hc3206615;
  int          bad_count = 0;
  int          checked = 0;
  // {ins, p2, p3, dir}; zero p2 means free, filled at random; zero p3 too, unless dir is 0
  logic [31:0] acc_t [22] = '{32'ha4000203, 32'hf2000002, 32'hb0000002, 32'hd6000001,
    32'hb2000002, 32'hdc000001, 32'ha2000003, 32'h32000303, 32'h20000801, 32'h24001001,
    32'h26010801, 32'h28010801, 32'h2c021001, 32'h04000000, 32'h44000000, 32'h88001003,
    32'hfa000000, 32'hc0000002, 32'h10000001, 32'hc2000003, 32'h12000002, 32'h14000001};
  always #2 clk = ~clk;
  apdu_decoder uut (.core_clk_in(clk), .resetn_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rdat),
    .wb_ack_out(ack), .rx_valid_in(rxv), .rx_byte_in(rxb), .tx_valid_out(txv),
    .tx_byte_out(txb));
  term_model u_term (.clk_in(clk), .tx_valid_in(txv), .tx_byte_in(txb), .rx_valid_out(rxv),
    .rx_byte_out(rxb));
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) bad_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wq(input int k);
    int n;
    n = 0;
    while (u_term.got_q.size() < k && n < 40) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic check_sw(input logic [15:0] exp);
    wq(2);
    repeat (2) @(posedge clk);
    check({u_term.got_q[0], u_term.got_q[1]}, {16'h0, exp});
    u_term.got_q.delete();
  endtask
  task automatic cmd(input logic [7:0] c, i, p1, p2, p3);
    u_term.send(c);
    u_term.send(i);
    u_term.send(p1);
    u_term.send(p2);
    u_term.send(p3);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    logic [7:0]  i8, p1, p2, p3, d, len;
    logic [1:0]  dir;
    logic [31:0] hdr;
    logic [7:0]  rsv [$];
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (acc_t[k]) begin
      {i8, p2, p3} = acc_t[k][31:8];
      dir = acc_t[k][1:0];
      p1 = xs();
      if (p2 == 8'h00) p2 = xs();
      if (p3 == 8'h00 && dir != 2'h0) p3 = xs() & 8'h07;
      if (i8 == `INS_PROFILE) p3 = 8'h00;
      if (i8 == `INS_RD_BIN) {p1, p2, p3} = 24'hffff00;
      cmd(8'ha0, i8, p1, p2, p3);
      hdr = {8'ha0, i8, p1, p2};
      bus(1'b0, `OFS_STAT, 32'h0);
      check(rd[10:0], {1'b1, dir, p3});
      if (dir == 2'h2) check(rd[24:16], (p3 == 8'h0) ? 32'd256 : p3);
      bus(1'b0, `OFS_HDR, 32'h0);
      check(rd, hdr);
      bus(1'b0, `OFS_OFFS, 32'h0);
      check(rd, {p1, p2});
      for (int n = 0; n < p3 && dir[0]; n++) begin
        d = xs();
        u_term.send(d);
      end
      if (dir[0] && p3 != 8'h0) bus(1'b0, `OFS_RXD, 32'h0);
      if (dir[0] && p3 != 8'h0) check(rd[7:0], d);
      bus(1'b1, `OFS_STAT, 32'h400);
      if (dir == 2'h2) begin
        d = xs();
        bus(1'b1, `OFS_TXD, {24'h0, d});
        wq(1);
        check(u_term.got_q.pop_front(), d);
      end
      if (dir == 2'h3) begin
        len = xs() | 8'h01;
        bus(1'b1, `OFS_PEND, {23'h0, i8 == `INS_ENVELOPE, len});
        check_sw({(i8 == `INS_ENVELOPE) ? 8'h9e : 8'h9f, len});
        cmd(8'ha0, `INS_GET_RSP, 8'h00, 8'h00, len);
        hdr = {8'ha0, `INS_GET_RSP, 16'h0};
        bus(1'b0, `OFS_PEND, 32'h0);
        check(rd[9], 1'b0);
      end
      bus(1'b1, `OFS_SW, 32'h9000);
      check_sw(16'h9000);
    end
    $display("accepted command test done");
    for (int x = 6; x <= 14; x += 2) rsv.push_back(8'h10 + x[7:0]);
    rsv = {rsv, 8'h2a, 8'hd0, 8'hd2, 8'hde, 8'hc4, 8'hc6, 8'hc8, 8'hca, 8'hcc, 8'hb4,
      8'hb6, 8'hb8, 8'hba, 8'hbc};
    foreach (rsv[k]) begin
      cmd(8'ha0, rsv[k], xs(), xs(), 8'h00);
      check_sw(16'h6d00);
    end
    $display("reserved code test done");
    d = xs();
    cmd((d == 8'ha0) ? 8'h00 : d, `INS_RD_BIN, 8'h00, 8'h00, 8'h04);
    check_sw(16'h6e00);
    cmd(8'ha0, `INS_SELECT, 8'h00, 8'h00, 8'h03);
    check_sw(16'h6700);
    cmd(8'ha0, `INS_DISABLE, 8'h00, 8'h02, 8'h08);
    check_sw(16'h6b00);
    bus(1'b0, `OFS_HDR, 32'h0);
    check(rd, hdr);
    $display("refusal test done");
    wrap_up();
  end
endmodule // subscriber_card_apdu_decoder_tb
`default_nettype wire
